// *** irq_vec_cfg.svh ***
`ifndef IRQ_VEC_CFG_SVH
`define IRQ_VEC_CFG_SVH
// register byte offsets
`define OFS_CORE_CONTROL   12'h000
`define OFS_IRQ_MASK       12'h004
`define OFS_IRQ_FLAGS      12'h008
`define OFS_PIN_CHANGE_MSK 12'h00C
`define OFS_CORE_STATUS    12'h010
`define OFS_VECTOR         12'h014
// field positions
`define SENSE_LO_BIT       0
`define SENSE_HI_BIT       1
`define SLEEP_DEEP_BIT     2
`define EXT_ENABLE_BIT     6
`define PC_ENABLE_BIT      5
`define EXT_FLAG_BIT       6
`define PC_FLAG_BIT        5
`define GLOBAL_IE_BIT      7
// reset values
`define PIN_CHANGE_MASK_RESET        6'h3F
// vector addresses
`define VEC_RESET          4'h0
`define VEC_EXT            4'h1
`define VEC_PCHG           4'h2
`define VEC_NUM            15
`endif

// *** irq_vec_pkg.sv ***
package irq_vec_pkg;
   typedef enum logic [1:0]
   {
      SENSE_LOW     = 2'b00,
      SENSE_CHANGE  = 2'b01,
      SENSE_FALLING = 2'b10,
      SENSE_RISING  = 2'b11
   } sense_e;
   // peripheral request lines, bit index plus three equals vector address
   typedef struct packed
   {
      logic serial_overflow_irq;
      logic serial_start_irq;
      logic watchdog_timeout_irq;
      logic timer_a_compare_b_irq;
      logic timer_a_compare_a_irq;
      logic timer_b_compare_b_irq;
      logic converter_irq;
      logic comparator_irq;
      logic nvm_ready_irq;
      logic timer_a_overflow_irq;
      logic timer_b_overflow_irq;
      logic timer_b_compare_a_irq;
   } periph_irq_s;
   // answer to the core fetch unit
   typedef struct packed
   {
      logic       valid;
      logic [3:0] addr;
   } vector_s;
endpackage : irq_vec_pkg

// *** irq_vector_ctrl.sv ***
// Operation
// [RULE_01] fifteen vectors at consecutive words; address zero is the shared reset vector
// [RULE_02] dedicated external pin interrupt fetches vector 0x0001
// [RULE_03] pin-change interrupt fetches vector 0x0002
// [RULE_04] second timer: compare-A 0x0003, overflow 0x0004, compare-B 0x0009
// [RULE_05] first timer: overflow 0x0005, compare-A 0x000A, compare-B 0x000B
// [RULE_06] nvm 6, comparator 7, converter 8, watchdog C, serial start D, overflow E
// [RULE_07] pin activity raises interrupts even when the pins are outputs
// [RULE_08] pin-change request on any toggle of an unmasked change input
// [RULE_09] pin changes detected without the I/O clock, waking every sleep mode
// [RULE_10] external interrupt triggers on falling edge, rising edge or low level
// [RULE_11] low-level mode keeps requesting while the pin stays low
// [RULE_12] external edges detected on the I/O clock only while it runs
// [RULE_13] low level detected without a clock, waking deep sleep
// [RULE_14] I/O clock stopped in all sleep modes except idle
// [RULE_15] a level wake source holds its level through the full start-up time
// [RULE_16] level gone before start-up ends: wake, but no level interrupt
// [RULE_17] sense field: 00 low, 01 any change, 10 falling, 11 rising
// [RULE_18] external flag set on edge, cleared by vector entry or write-one, clear in level mode
// [RULE_19] pin-change flag set on change, cleared by vector entry or write-one
// [RULE_20] taken only with individual enable and global enable both set
// [RULE_21] lowest pending vector address dispatched first
// [RULE_22] external pin synchronised on the I/O clock before edge compare
`timescale 1ns/100ps
`include "irq_vec_cfg.svh"
`default_nettype none
module irq_vector_ctrl
   import irq_vec_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // pins, sampled whatever their direction
   input  wire logic        ext_irq_pin,
   input  wire logic [5:0]  pin_change_inputs,
   // peripheral requests and core handshake
   input  wire periph_irq_s periph_irq,
   input  wire logic        vector_ack,
   input  wire logic        startup_done,
   output vector_s          vector_q,
   output logic             wake_req
);
   //////////////////////////////////////////////////////////////////////////
   // register state
   logic [1:0]  sense_q;
   logic        sleep_deep_q;
   logic        ext_en_q;
   logic        pc_en_q;
   logic        gie_q;
   logic [5:0]  pin_change_mask;
   logic        ext_irq_flag;
   logic        pin_change_flag;
   // ahb address phase capture
   logic        wr_q;
   logic        rd_q;
   logic [11:0] addr_q;

   // zero wait state slave, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // address phase is taken when selected and the bus is ready
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 12'h000;
      end
      else if (hready)
      begin
         wr_q   <= hsel & htrans[1] & hwrite;
         rd_q   <= hsel & htrans[1] & ~hwrite;
         addr_q <= {haddr[11:2], 2'b00};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the pin-change path also feeds an asynchronous wake
   logic        ext_s1_q;
   logic        ext_s2_q;
   logic        ext_prev_q;
   logic [5:0]  pc_s1_q;
   logic [5:0]  pc_s2_q;
   logic [5:0]  pc_prev_q;
   logic        io_clk_run;

   // sleep other than idle halts the io clock, modelled as a gate
   assign io_clk_run = ~sleep_deep_q; // RULE_14

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ext_s1_q   <= 1'b1;
         ext_s2_q   <= 1'b1;
         ext_prev_q <= 1'b1;
         pc_s1_q    <= 6'h00;
         pc_s2_q    <= 6'h00;
         pc_prev_q  <= 6'h00;
      end
      else
      begin
         ext_s1_q  <= ext_irq_pin; // RULE_22
         ext_s2_q  <= ext_s1_q;
         pc_s1_q   <= pin_change_inputs;
         pc_s2_q   <= pc_s1_q;
         pc_prev_q <= pc_s2_q;
         // frozen edge history while the io clock is stopped
         if (io_clk_run)
            ext_prev_q <= ext_s2_q; // RULE_12
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // event detection
   logic ext_edge;
   logic ext_low;
   logic pc_event;

   // sense decode
   always_comb
   begin
      case (sense_e'(sense_q)) // RULE_17 RULE_10
         SENSE_CHANGE:  ext_edge = io_clk_run & (ext_s2_q ^ ext_prev_q);
         SENSE_FALLING: ext_edge = io_clk_run & ext_prev_q & ~ext_s2_q;
         SENSE_RISING:  ext_edge = io_clk_run & ~ext_prev_q & ext_s2_q;
         default:       ext_edge = 1'b0;
      endcase
   end

   // low level needs no edge history, so it works in deep sleep
   assign ext_low  = (sense_q == SENSE_LOW) & ~ext_s2_q; // RULE_13 RULE_11
   // any unmasked toggle, independent of the io clock gate
   assign pc_event = |((pc_s2_q ^ pc_prev_q) & pin_change_mask); // RULE_08 RULE_09 RULE_07

   // wake from level held until start-up completes, else no interrupt
   logic level_req;
   assign level_req = ext_low & startup_done; // RULE_16
   assign wake_req  = (ext_low & ext_en_q) | (pc_event & pc_en_q);

   //////////////////////////////////////////////////////////////////////////
   // vector selection and dispatch
   logic [14:0] pending;
   logic [3:0]  sel_addr;
   logic        sel_any;
   logic        gated_ext;
   logic        gated_pc;

   assign gated_ext = gie_q & ext_en_q & (ext_irq_flag | level_req); // RULE_20
   assign gated_pc  = gie_q & pc_en_q & pin_change_flag; // RULE_20
   // peripherals sit at addresses 3..14 in struct order
   assign pending = {periph_irq & {12{gie_q}}, gated_pc, gated_ext, 1'b0}; // RULE_04 RULE_05 RULE_06

   // lowest address wins
   function automatic logic [3:0] first_set(input logic [14:0] v);
      logic [3:0] r;
      r = `VEC_RESET;
      for (int i = `VEC_NUM - 1; i >= 1; i--)
         if (v[i])
            r = 4'(i);
      return r;
   endfunction : first_set

   assign sel_addr = first_set(pending); // RULE_21
   assign sel_any  = |pending;

   // vector held until the core acknowledges; reset shows address zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         vector_q <= '{valid: 1'b0, addr: `VEC_RESET}; // RULE_01
      else if (vector_q.valid && vector_ack)
         vector_q.valid <= 1'b0;
      else if (!vector_q.valid && sel_any)
         vector_q <= '{valid: 1'b1, addr: sel_addr}; // RULE_02 RULE_03
   end

   logic take_ext;
   logic take_pc;
   assign take_ext = vector_q.valid & vector_ack & (vector_q.addr == `VEC_EXT);
   assign take_pc  = vector_q.valid & vector_ack & (vector_q.addr == `VEC_PCHG);

   //////////////////////////////////////////////////////////////////////////
   // flags; a new event wins over a clear in the same cycle
   logic wr_flags;
   assign wr_flags = wr_q & (addr_q == `OFS_IRQ_FLAGS);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ext_irq_flag <= 1'b0;
      else if (sense_q == SENSE_LOW)
         ext_irq_flag <= 1'b0; // RULE_18
      else if (ext_edge)
         ext_irq_flag <= 1'b1; // RULE_18
      else if (take_ext || (wr_flags && hwdata[`EXT_FLAG_BIT]))
         ext_irq_flag <= 1'b0; // RULE_18
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pin_change_flag <= 1'b0;
      else if (pc_event)
         pin_change_flag <= 1'b1; // RULE_19
      else if (take_pc || (wr_flags && hwdata[`PC_FLAG_BIT]))
         pin_change_flag <= 1'b0; // RULE_19
   end

   //////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sense_q         <= 2'b00;
         sleep_deep_q    <= 1'b0;
         ext_en_q        <= 1'b0;
         pc_en_q         <= 1'b0;
         gie_q           <= 1'b0;
         pin_change_mask <= `PIN_CHANGE_MASK_RESET;
      end
      else if (wr_q)
      begin
         case (addr_q)
            `OFS_CORE_CONTROL:
            begin
               sense_q      <= hwdata[`SENSE_HI_BIT:`SENSE_LO_BIT];
               sleep_deep_q <= hwdata[`SLEEP_DEEP_BIT];
            end
            `OFS_IRQ_MASK:
            begin
               ext_en_q <= hwdata[`EXT_ENABLE_BIT];
               pc_en_q  <= hwdata[`PC_ENABLE_BIT];
            end
            `OFS_PIN_CHANGE_MSK: pin_change_mask <= hwdata[5:0];
            `OFS_CORE_STATUS:    gie_q           <= hwdata[`GLOBAL_IE_BIT];
            default:             ;
         endcase
      end
   end

   // read mux; unmapped reads zero
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (rd_q)
      begin
         case (addr_q)
            `OFS_CORE_CONTROL:
            begin
               hrdata[`SENSE_HI_BIT:`SENSE_LO_BIT] = sense_q;
               hrdata[`SLEEP_DEEP_BIT]             = sleep_deep_q;
            end
            `OFS_IRQ_MASK:
            begin
               hrdata[`EXT_ENABLE_BIT] = ext_en_q;
               hrdata[`PC_ENABLE_BIT]  = pc_en_q;
            end
            `OFS_IRQ_FLAGS:
            begin
               hrdata[`EXT_FLAG_BIT] = ext_irq_flag;
               hrdata[`PC_FLAG_BIT]  = pin_change_flag;
            end
            `OFS_PIN_CHANGE_MSK: hrdata[5:0] = pin_change_mask;
            `OFS_CORE_STATUS:    hrdata[`GLOBAL_IE_BIT] = gie_q;
            `OFS_VECTOR:         hrdata[4:0] = {vector_q.valid, vector_q.addr};
            default:             hrdata = 32'h0000_0000;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   a_vec_held: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_21
      vector_q.valid && !vector_ack |=> vector_q.valid && $stable(vector_q.addr))
      else $error("vector dropped before ack");
   a_level_flag_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
      sense_q == SENSE_LOW |=> !ext_irq_flag)
      else $error("ext flag set in level mode");
   a_pc_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_19
      pc_event |=> pin_change_flag)
      else $error("pin change flag missed");
   a_edge_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
      ext_edge && sense_q != SENSE_LOW |=> ext_irq_flag)
      else $error("ext flag missed edge");
   a_no_edge_asleep: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14
      sleep_deep_q |-> !ext_edge)
      else $error("edge seen with io clock off");
   a_gie_gate: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_20
      !gie_q && !vector_q.valid |=> !vector_q.valid)
      else $error("vector without global enable");
   a_ext_vector: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
      !vector_q.valid && gated_ext |=> vector_q.addr == `VEC_EXT)
      else $error("ext not at vector one");
   a_pc_vector: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
      !vector_q.valid && gated_pc && !gated_ext |=> vector_q.addr == `VEC_PCHG)
      else $error("pin change not at vector two");
   a_level_repeat: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
      ext_low && startup_done && ext_en_q && gie_q && !vector_q.valid |=> vector_q.valid)
      else $error("level request not raised");

   // named steps used by the dispatch and wake checks
   sequence s_vec_taken;
      vector_q.valid && vector_ack;
   endsequence : s_vec_taken
   sequence s_level_held;
      ext_en_q && (sense_q == SENSE_LOW) && !ext_s2_q;
   endsequence : s_level_held

   // an acknowledged vector is retired on the same edge
   a_ack_retires: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_21
      s_vec_taken |=> !vector_q.valid)
      else $error("vector kept after ack");
   // vector entry clears its own flag unless a new event lands with it
   a_ext_take_clears: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
      take_ext && !ext_edge |=> !ext_irq_flag)
      else $error("ext flag kept after vector entry");
   a_pc_take_clears: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_19
      take_pc && !pc_event |=> !pin_change_flag)
      else $error("pin change flag kept after vector entry");

   // write-one clears lose to a new event in the same cycle
   a_ext_w1c: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
      wr_flags && hwdata[`EXT_FLAG_BIT] && !ext_edge |=> !ext_irq_flag)
      else $error("ext flag not cleared by write");
   a_pc_w1c: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_19
      wr_flags && hwdata[`PC_FLAG_BIT] && !pc_event |=> !pin_change_flag)
      else $error("pin change flag not cleared by write");

   // level wake needs no clock and no flag
   a_level_wake: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
      s_level_held |-> wake_req)
      else $error("held low level gives no wake");
   // a level that vanishes before start-up ends dispatches nothing
   a_level_early: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
      sense_q == SENSE_LOW && !startup_done && !ext_irq_flag && !gated_pc
         && !(|periph_irq) && !vector_q.valid |=> !vector_q.valid)
      else $error("level vector before start-up done");
endmodule : irq_vector_ctrl
`default_nettype wire

// *** core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module core_model
   import irq_vec_pkg::*;
(
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // fetch handshake
   input  wire vector_s    vector_q,
   input  wire logic [1:0] slow,
   output logic            vector_ack
);
   logic [1:0] wait_q;
   logic       drain_q;
   // take a vector after 0..3 cycles; never ack twice before valid drops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         vector_ack <= 1'b0;
         wait_q     <= 2'h0;
         drain_q    <= 1'b0;
      end
      else if (vector_ack)
      begin
         vector_ack <= 1'b0;
         drain_q    <= 1'b1;
      end
      else if (drain_q)
         drain_q <= vector_q.valid;
      else if (vector_q.valid && wait_q >= slow)
      begin
         vector_ack <= 1'b1;
         wait_q     <= 2'h0;
      end
      else if (vector_q.valid)
         wait_q <= wait_q + 2'h1;
   end
endmodule : core_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`include "irq_vec_cfg.svh"
`default_nettype none
module testbench
   import irq_vec_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_irq_pin;
   logic        vector_ack, startup_done, wake_req;
   logic [11:0] haddr;
   logic [1:0]  htrans, slow;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [5:0]  pin_change_inputs;
   periph_irq_s periph_irq;
   vector_s     vector_q;
   int          err_total, comparisons, i;
   logic [1:0]  sense_tab [4] = '{2'b10, 2'b11, 2'b01, 2'b01};
   logic        pin_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

   irq_vector_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(ext_irq_pin),
      .pin_change_inputs(pin_change_inputs), .periph_irq(periph_irq),
      .vector_ack(vector_ack), .startup_done(startup_done), .vector_q(vector_q),
      .wake_req(wake_req));
   core_model core_u (.hclk(hclk), .hresetn(hresetn), .vector_q(vector_q), .slow(slow),
      .vector_ack(vector_ack));

   // 40 mhz
   always #12.5 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk

   // lowest pending vector wins
   function automatic int lowest(input logic [14:0] p);
      for (int k = 0; k < 15; k++)
         if (p[k])
            return k;
      return 0;
   endfunction : lowest

   // single ahb-lite word transfer, waits on hready in both phases
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      for (n = 0; n < 16; n++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            break;
      end
      if (n == 16)
      begin
         err_total++;
         summarize();
      end
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      for (n = 0; n < 16; n++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            break;
      end
      rd = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
      if (n == 16)
      begin
         err_total++;
         summarize();
      end
   endtask : ahb

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rd_chk

   // the core answer arrives after an unknown number of cycles
   task automatic wait_vec(input int e);
      slow <= 2'($urandom % 4);
      for (int n = 0; n < 64; n++)
      begin
         @(posedge hclk);
         if (vector_ack === 1'b1 && vector_q.valid === 1'b1)
         begin
            chk("vector", 32'(e), 32'(vector_q.addr));
            return;
         end
      end
      err_total++;
      summarize();
   endtask : wait_vec

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {hclk, hresetn, hsel, hwrite, htrans, haddr, hsize, hwdata, slow} = '0;
      {periph_irq, pin_change_inputs} = '0;
      ext_irq_pin  = 1'b1;
      startup_done = 1'b1;
      err_total    = 0;
      comparisons  = 0;
      void'($urandom(32'hC1A5FCAF));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      chk("reset vector", 32'h0, 32'(vector_q));
      rd_chk("mask reset", `OFS_PIN_CHANGE_MSK, 32'h3F);
      rd_chk("vector idle", `OFS_VECTOR, 32'h0);
      ahb(1'b1, `OFS_CORE_STATUS, 32'h80);
      for (i = 0; i < 12; i++)
      begin
         periph_irq <= periph_irq_s'(12'h1 << i);
         wait_vec(i + 3);
         periph_irq <= '0;
         repeat (4) @(posedge hclk);
      end
      // pin change and all peripherals at once
      ahb(1'b1, `OFS_IRQ_MASK, 32'h20);
      pin_change_inputs <= pin_change_inputs ^ (6'h1 << ($urandom % 6));
      repeat (4) @(posedge hclk);
      periph_irq <= '1;
      wait_vec(lowest(15'h7FFC));
      wait_vec(lowest(15'h7FF8));
      periph_irq <= '0;
      for (i = 0; i < 4; i++)
      begin
         ahb(1'b1, `OFS_CORE_CONTROL, 32'(sense_tab[i]));
         ahb(1'b1, `OFS_IRQ_MASK, 32'h40);
         ext_irq_pin <= pin_tab[i];
         wait_vec(1);
      end
      // no edge seen with the i/o clock stopped
      ahb(1'b1, `OFS_CORE_CONTROL, 32'h6);
      ext_irq_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      chk("deep sleep edge", 32'h0, 32'(vector_q.valid));
      ext_irq_pin <= 1'b1;
      ahb(1'b1, `OFS_CORE_CONTROL, 32'h0);
      ext_irq_pin <= 1'b0;
      wait_vec(1);
      wait_vec(1);
      startup_done <= 1'b0;
      rd_chk("level flag", `OFS_IRQ_FLAGS, 32'h0);
      chk("wake", 32'h1, 32'(wake_req));
      chk("level early", 32'h0, 32'(vector_q.valid));
      ext_irq_pin  <= 1'b1;
      // flags without global enable, then write-one clear
      ahb(1'b1, `OFS_CORE_STATUS, 32'h0);
      // start-up ends only once the synced pin is high again and global enable is off
      startup_done <= 1'b1;
      ahb(1'b1, `OFS_CORE_CONTROL, 32'h2);
      ahb(1'b1, `OFS_IRQ_MASK, 32'h60);
      pin_change_inputs <= pin_change_inputs ^ 6'h4;
      ext_irq_pin       <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("no global", 32'h0, 32'(vector_q.valid));
      rd_chk("flags", `OFS_IRQ_FLAGS, 32'h60);
      ahb(1'b1, `OFS_IRQ_FLAGS, 32'h60);
      rd_chk("flags clear", `OFS_IRQ_FLAGS, 32'h0);
      ahb(1'b1, `OFS_PIN_CHANGE_MSK, 32'h1);
      pin_change_inputs <= pin_change_inputs ^ 6'h8;
      repeat (6) @(posedge hclk);
      rd_chk("masked pin", `OFS_IRQ_FLAGS, 32'h0);
      rd_chk("unmapped", 12'h0FC, 32'h0);
      summarize();
   end
endmodule : testbench
`default_nettype wire
